//--- core/stmc_pkg.sv
package stmc_pkg;

	localparam logic [3:0] ADR_CTRL_A   = 4'h0;
	localparam logic [3:0] ADR_CTRL_B   = 4'h1;
	localparam logic [3:0] ADR_CNT_LO   = 4'h2;
	localparam logic [3:0] ADR_CNT_HI   = 4'h3;
	localparam logic [3:0] ADR_CMP_LO   = 4'h4;
	localparam logic [3:0] ADR_CMP_HI   = 4'h5;
	localparam logic [3:0] ADR_PERIOD   = 4'h6;
	localparam logic [3:0] ADR_STATUS   = 4'h7;

	localparam int POS_PAUSE = 7;
	localparam int POS_CKSEL = 4;
	localparam int POS_ON    = 3;

	localparam logic [7:0] RST_CTRL_A = 8'h00;
	localparam logic [7:0] RST_CTRL_B = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'h00;
	localparam logic [15:0] RST_CMP   = 16'h0000;
	localparam logic [7:0] CTRL_A_MASK = 8'hf8;

	localparam int DIV_SYS4  = 4;
	localparam int DIV_H16   = 16;
	localparam int DIV_H64   = 64;

	typedef enum logic [1:0] {
		STMC_MODE_CMP  = 2'b00,
		STMC_MODE_CAP  = 2'b01,
		STMC_MODE_PWM  = 2'b10,
		STMC_MODE_TMR  = 2'b11
	} stmc_mode_e;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] func;
		logic       oc;
		logic       pol;
		logic       dpx;
		logic       cclr;
	} stmc_ctrl_b_s;

	typedef struct packed {
		logic cmp_a_match;
		logic cmp_p_match;
		logic captured;
	} stmc_evt_s;

endpackage

//--- core/stmc_core.sv
`timescale 1ns/1ps
// How it works
// - 16-bit up-counter advances on each tick of the selected clock source.
// - Period match compares all 16 counter bits with 256 times the period byte minus one; compare value compares all 16 bits.
// - On bit rising edge zeroes counter; software cannot write the counter otherwise.
// - Counter clears on overflow or selected comparator match; a match clear raises an event, overflow none.
// - Pause bit freezes counter in place; clearing it resumes from held value.
// - Clock select: sys/4, sys, high/16, high/64, time base, pin rise, pin fall.
// - On bit low stops counting and keeps value; high enables counting.
// - Compare mode: on bit rising edge loads output with initial level.
// - Mode field: compare output, capture, PWM or single pulse, plain timer.
// - Compare mode match: keep, drive low, drive high, or toggle output.
// - PWM mode function: forced inactive, forced active, PWM, single pulse.
// - Capture mode function selects edge: rising, falling, both, disabled.
// - A match requesting the level already present changes nothing visible.
// - Output control bit: initial level in compare, active level in PWM.
// - Polarity bit inverts output pin; no effect in plain timer mode.
// - Swap bit in PWM mode 0: period byte sets period; 1: compare value sets period.
// - Clear select outside PWM mode 1 uses 16-bit match; 0 uses period match or overflow.
// - Counter readable as two read-only bytes, reset to zero.
// - Compare value held in two read/write bytes, reset to zero.
// - Period byte zero gives 65536 clocks; otherwise 256 times its value.
module stmc_core #(
	parameter int CNT_W = 16
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [7:0]  wb_dat_i,
	input  wire logic        wb_sel_i,
	output logic      [7:0]  wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        high_speed_clock_en,
	input  wire logic        time_base_clock_en,
	input  wire logic        external_clock_pin,
	input  wire logic        capture_input_pin,
	output logic             timer_out,
	output logic             timer_out_en,
	output logic             match_a_pulse,
	output logic             match_p_pulse,
	output logic             capture_pulse
);

	logic [7:0]          ctrl_a_r, ctrl_a_nxt;
	stmc_pkg::stmc_ctrl_b_s ctrl_b_r, ctrl_b_nxt;
	logic [15:0]         cmp_r, cmp_nxt;
	logic [7:0]          per_r, per_nxt;
	logic [15:0]         cnt_r, cnt_nxt;
	logic [15:0]         cap_r, cap_nxt;
	logic [2:0]          sts_r, sts_nxt;
	logic                ack_r, ack_nxt;
	logic [7:0]          rdat_r, rdat_nxt;
	logic [5:0]          div_r, div_nxt;
	logic                on_q_r, on_q_nxt;
	logic                ext_q_r, ext_q_nxt;
	logic                capin_q_r, capin_q_nxt;
	logic                lvl_r, lvl_nxt;
	logic                pulse_done_r, pulse_done_nxt;
	stmc_pkg::stmc_evt_s evt_r, evt_nxt;

	logic                on_bit, pause_bit, on_rise, tick, match_a, match_p, clr;
	logic                wr, rd_en, cap_edge;
	logic [2:0]          cksel;
	stmc_pkg::stmc_mode_e mode;
	logic [16:0]         per_top, duty_val;
	logic                pwm_act;

	function automatic logic [16:0] per_span(input logic [7:0] p);
		per_span = (p == 8'h00) ? 17'h10000 : {1'b0, p, 8'h00};
	endfunction

	assign on_bit    = ctrl_a_r[stmc_pkg::POS_ON];
	assign pause_bit = ctrl_a_r[stmc_pkg::POS_PAUSE];
	assign cksel     = ctrl_a_r[stmc_pkg::POS_CKSEL +: 3];
	assign mode      = stmc_pkg::stmc_mode_e'(ctrl_b_r.mode);
	assign on_rise   = on_bit && !on_q_r;
	assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !ack_r;
	assign rd_en     = wb_cyc_i && wb_stb_i && !ack_r;

	always_comb
	begin
		div_nxt = div_r + 6'h01;
		tick    = 1'b0;
		case (cksel)
			3'h0: tick = (div_r[1:0] == 2'(stmc_pkg::DIV_SYS4 - 1));
			3'h1: tick = 1'b1;
			3'h2: tick = high_speed_clock_en && (div_r[3:0] == 4'(stmc_pkg::DIV_H16 - 1));
			3'h3: tick = high_speed_clock_en && (div_r == 6'(stmc_pkg::DIV_H64 - 1));
			3'h4, 3'h5: tick = time_base_clock_en;
			3'h6: tick = external_clock_pin && !ext_q_r;
			3'h7: tick = !external_clock_pin && ext_q_r;
			default: tick = 1'b0;
		endcase
		// High clock dividers count only its enable pulses
		if ((cksel == 3'h2 || cksel == 3'h3) && !high_speed_clock_en)
			div_nxt = div_r;
		ext_q_nxt = external_clock_pin;
		capin_q_nxt = capture_input_pin;
		on_q_nxt = on_bit;
	end

	always_comb
	begin
		// Match on the last count so the period is exactly 256 x value ticks
		match_p = (per_r != 8'h00) && (cnt_r == ({per_r, 8'h00} - 16'h0001));
		match_a = (cnt_r == cmp_r);
		if (mode == stmc_pkg::STMC_MODE_PWM)
			clr = ctrl_b_r.dpx ? match_a : (match_p || (per_r == 8'h00 && &cnt_r));
		else if (ctrl_b_r.cclr)
			clr = match_a;
		else
			clr = match_p || (per_r == 8'h00 && &cnt_r);
		if (ctrl_b_r.dpx)
		begin
			per_top  = {1'b0, cmp_r} + 17'h1;
			duty_val = per_span(per_r);
		end
		else
		begin
			per_top  = per_span(per_r);
			duty_val = {1'b0, cmp_r};
		end
		pwm_act = ({1'b0, cnt_r} < duty_val);
		case (ctrl_b_r.func)
			2'b00: cap_edge = capture_input_pin && !capin_q_r;
			2'b01: cap_edge = !capture_input_pin && capin_q_r;
			2'b10: cap_edge = capture_input_pin != capin_q_r;
			default: cap_edge = 1'b0;
		endcase
		if (mode != stmc_pkg::STMC_MODE_CAP || !on_bit)
			cap_edge = 1'b0;
	end

	always_comb
	begin
		cnt_nxt = cnt_r;
		cap_nxt = cap_r;
		lvl_nxt = lvl_r;
		pulse_done_nxt = pulse_done_r;
		evt_nxt = '0;
		if (on_rise)
		begin
			cnt_nxt = 16'h0000;
			pulse_done_nxt = 1'b0;
			if (mode == stmc_pkg::STMC_MODE_CMP)
				lvl_nxt = ctrl_b_r.oc;
		end
		else if (on_bit && !pause_bit && tick)
		begin
			evt_nxt.cmp_a_match = match_a;
			evt_nxt.cmp_p_match = match_p && !(ctrl_b_r.cclr && mode != stmc_pkg::STMC_MODE_PWM);
			if (clr)
			begin
				cnt_nxt = 16'h0000;
				if (mode == stmc_pkg::STMC_MODE_PWM && ctrl_b_r.func == 2'b11)
					pulse_done_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r + 16'h0001;
			if (mode == stmc_pkg::STMC_MODE_CMP && match_a)
			begin
				// Same level as present leaves pin untouched
				case (ctrl_b_r.func)
					2'b01: lvl_nxt = 1'b0;
					2'b10: lvl_nxt = 1'b1;
					2'b11: lvl_nxt = !lvl_r;
					default: lvl_nxt = lvl_r;
				endcase
			end
		end
		if (cap_edge)
		begin
			cap_nxt = cnt_r;
			evt_nxt.captured = 1'b1;
		end
	end

	always_comb
	begin
		timer_out = lvl_r;
		timer_out_en = 1'b1;
		case (mode)
			stmc_pkg::STMC_MODE_PWM:
				case (ctrl_b_r.func)
					2'b00: timer_out = !ctrl_b_r.oc;
					2'b01: timer_out = ctrl_b_r.oc;
					2'b10: timer_out = (pwm_act && on_bit) ? ctrl_b_r.oc : !ctrl_b_r.oc;
					default: timer_out = (on_bit && !pulse_done_r && pwm_act && per_top != 17'h0)
						? ctrl_b_r.oc : !ctrl_b_r.oc;
				endcase
			stmc_pkg::STMC_MODE_CAP: timer_out = 1'b0;
			default: timer_out = lvl_r;
		endcase
		if (mode == stmc_pkg::STMC_MODE_TMR)
		begin
			timer_out = 1'b0;
			timer_out_en = 1'b0;
		end
		else
			timer_out = timer_out ^ ctrl_b_r.pol;
	end

	assign match_a_pulse = evt_r.cmp_a_match;
	assign match_p_pulse = evt_r.cmp_p_match;
	assign capture_pulse = evt_r.captured;

	always_comb
	begin
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		cmp_nxt = cmp_r;
		per_nxt = per_r;
		sts_nxt = sts_r | {evt_r.cmp_a_match, evt_r.cmp_p_match, evt_r.captured};
		ack_nxt = rd_en;
		rdat_nxt = rdat_r;
		if (wr)
		begin
			case (wb_adr_i)
				stmc_pkg::ADR_CTRL_A: ctrl_a_nxt = wb_dat_i & stmc_pkg::CTRL_A_MASK;
				stmc_pkg::ADR_CTRL_B: ctrl_b_nxt = wb_dat_i;
				stmc_pkg::ADR_CMP_LO: cmp_nxt[7:0] = wb_dat_i;
				stmc_pkg::ADR_CMP_HI: cmp_nxt[15:8] = wb_dat_i;
				stmc_pkg::ADR_PERIOD: per_nxt = wb_dat_i;
				// Write one to clear; a new event in the same cycle wins
				stmc_pkg::ADR_STATUS: sts_nxt = (sts_r & ~wb_dat_i[2:0])
					| {evt_r.cmp_a_match, evt_r.cmp_p_match, evt_r.captured};
				default: ;
			endcase
		end
		if (rd_en && !wb_we_i)
		begin
			case (wb_adr_i)
				stmc_pkg::ADR_CTRL_A: rdat_nxt = ctrl_a_r;
				stmc_pkg::ADR_CTRL_B: rdat_nxt = ctrl_b_r;
				stmc_pkg::ADR_CNT_LO: rdat_nxt = cnt_r[7:0];
				stmc_pkg::ADR_CNT_HI: rdat_nxt = cnt_r[15:8];
				stmc_pkg::ADR_CMP_LO: rdat_nxt = cmp_r[7:0];
				stmc_pkg::ADR_CMP_HI: rdat_nxt = cmp_r[15:8];
				stmc_pkg::ADR_PERIOD: rdat_nxt = per_r;
				stmc_pkg::ADR_STATUS: rdat_nxt = {5'h00, sts_r};
				4'h8: rdat_nxt = cap_r[7:0];
				4'h9: rdat_nxt = cap_r[15:8];
				default: rdat_nxt = 8'h00;
			endcase
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			ctrl_a_r <= stmc_pkg::RST_CTRL_A;
			ctrl_b_r <= stmc_pkg::RST_CTRL_B;
			cmp_r <= stmc_pkg::RST_CMP;
			per_r <= stmc_pkg::RST_PERIOD;
			cnt_r <= 16'h0000;
			cap_r <= 16'h0000;
			sts_r <= 3'h0;
			ack_r <= 1'b0;
			rdat_r <= 8'h00;
			div_r <= 6'h00;
			on_q_r <= 1'b0;
			ext_q_r <= 1'b0;
			capin_q_r <= 1'b0;
			lvl_r <= 1'b0;
			pulse_done_r <= 1'b0;
			evt_r <= '0;
		end
		else
		begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			cmp_r <= cmp_nxt;
			per_r <= per_nxt;
			cnt_r <= cnt_nxt;
			cap_r <= cap_nxt;
			sts_r <= sts_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
			div_r <= div_nxt;
			on_q_r <= on_q_nxt;
			ext_q_r <= ext_q_nxt;
			capin_q_r <= capin_q_nxt;
			lvl_r <= lvl_nxt;
			pulse_done_r <= pulse_done_nxt;
			evt_r <= evt_nxt;
		end
	end

	a_on_rise_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		on_rise |=> cnt_r == 16'h0000)
		else $error("counter not cleared on enable");
	a_pause_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pause_bit && on_q_r && $past(pause_bit)) |-> $stable(cnt_r))
		else $error("counter moved while paused");
	a_off_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!on_bit && !$past(on_bit)) |=> $stable(cnt_r))
		else $error("counter moved while off");
	a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(on_bit && on_q_r && !pause_bit && tick && !clr) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("counter did not step");
	a_clear_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(on_bit && on_q_r && !pause_bit && tick && clr) |=> cnt_r == 16'h0000)
		else $error("counter not cleared on match");
	a_init_level: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(on_rise && mode == stmc_pkg::STMC_MODE_CMP) |=> lvl_r == $past(ctrl_b_r.oc))
		else $error("initial level not loaded");
	a_timer_no_pin: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode == stmc_pkg::STMC_MODE_TMR |-> !timer_out_en && !timer_out)
		else $error("pin driven in timer mode");
	a_wb_ack_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_period_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
		match_p |-> cnt_r == ({per_r, 8'h00} - 16'h0001))
		else $error("period match at wrong count");

	// Compare output actions; on_q_r excludes the switch-on cycle
	a_cmp_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_CMP && on_bit && on_q_r && !pause_bit && tick && match_a
		&& ctrl_b_r.func == 2'b11) |=> lvl_r != $past(lvl_r))
		else $error("output did not toggle");
	a_cmp_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_CMP && on_bit && on_q_r && !pause_bit && tick && match_a
		&& ctrl_b_r.func == 2'b10) |=> lvl_r)
		else $error("output not driven high");
	a_cmp_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_CMP && on_bit && on_q_r && !pause_bit && tick && match_a
		&& ctrl_b_r.func == 2'b01) |=> !lvl_r)
		else $error("output not driven low");
	a_cmp_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_CMP && on_bit && on_q_r && !pause_bit && tick && match_a
		&& ctrl_b_r.func == 2'b00) |=> $stable(lvl_r))
		else $error("output changed with no action");
	a_cmp_polarity: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode == stmc_pkg::STMC_MODE_CMP |-> timer_out == (lvl_r ^ ctrl_b_r.pol))
		else $error("polarity not applied");
	a_pwm_active: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_PWM && ctrl_b_r.func == 2'b01)
		|-> timer_out == (ctrl_b_r.oc ^ ctrl_b_r.pol))
		else $error("forced active level wrong");
	a_pwm_inactive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_PWM && ctrl_b_r.func == 2'b00)
		|-> timer_out == (!ctrl_b_r.oc ^ ctrl_b_r.pol))
		else $error("forced inactive level wrong");
	a_pwm_wave: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_PWM && ctrl_b_r.func == 2'b10 && on_bit && cnt_r == 16'h0000
		&& duty_val != 17'h0) |-> timer_out == (ctrl_b_r.oc ^ ctrl_b_r.pol))
		else $error("pwm not active at period start");
	a_swap_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_PWM && ctrl_b_r.dpx && on_bit && on_q_r && !pause_bit
		&& tick && match_a) |=> cnt_r == 16'h0000)
		else $error("swapped period did not clear");
	a_ovf_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode != stmc_pkg::STMC_MODE_PWM && !ctrl_b_r.cclr && per_r == 8'h00 && &cnt_r
		&& on_bit && on_q_r && !pause_bit && tick) |=> cnt_r == 16'h0000)
		else $error("overflow did not clear");
	a_cap_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cap_edge |=> cap_r == $past(cnt_r) && capture_pulse)
		else $error("capture not latched");
	a_cap_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode == stmc_pkg::STMC_MODE_CAP && ctrl_b_r.func == 2'b11) |-> !cap_edge)
		else $error("capture while disabled");

	// Bus side: read data is the value at the request, presented one cycle later
	a_cnt_lo_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(rd_en && !wb_we_i && wb_adr_i == stmc_pkg::ADR_CNT_LO) |=> wb_dat_o == $past(cnt_r[7:0]))
		else $error("counter low read wrong");
	a_cnt_hi_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(rd_en && !wb_we_i && wb_adr_i == stmc_pkg::ADR_CNT_HI) |=> wb_dat_o == $past(cnt_r[15:8]))
		else $error("counter high read wrong");
	a_cmp_lo_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && wb_adr_i == stmc_pkg::ADR_CMP_LO) |=> cmp_r[7:0] == $past(wb_dat_i))
		else $error("compare low not written");
	a_cmp_hi_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(wr && wb_adr_i == stmc_pkg::ADR_CMP_HI) |=> cmp_r[15:8] == $past(wb_dat_i))
		else $error("compare high not written");

endmodule // stmc_core

//--- verification/stmc_tb.sv
`timescale 1ns/1ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [3:0]  adr     = 4'h0;
	logic [7:0]  dat     = 8'h00;
	logic        cap     = 1'b0;
	logic [1:0]  ec      = 2'h0;
	logic [7:0]  wb_dat_o;
	logic        wb_ack_o;
	logic        timer_out;
	logic        timer_out_en;
	logic        match_a_pulse;
	logic        match_p_pulse;
	logic        capture_pulse;
	logic [7:0]  q;
	logic [7:0]  qa;
	int          err_total   = 0;
	int          check_count = 0;
	int          n;
	int          h;
	logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
	logic [7:0]  rw [8] = '{8'hf7, 8'ha5, 8'hff, 8'hff, 8'h3c, 8'hc3, 8'h5a, 8'hff};
	logic [7:0]  re [8] = '{8'hf0, 8'ha5, 8'h00, 8'h00, 8'h3c, 8'hc3, 8'h5a, 8'h00};
	logic [2:0]  cs [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	int          cg [7] = '{1024, 256, 4096, 16384, 256, 1024, 1024};

	stmc_core i_dut (
		.clk_sys             (clk_sys),
		.sys_rst             (sys_rst),
		.wb_cyc_i            (cyc),
		.wb_stb_i            (stb),
		.wb_we_i             (we),
		.wb_adr_i            (adr),
		.wb_dat_i            (dat),
		.wb_sel_i            (1'b1),
		.wb_dat_o            (wb_dat_o),
		.wb_ack_o            (wb_ack_o),
		.high_speed_clock_en (1'b1),
		.time_base_clock_en  (1'b1),
		.external_clock_pin  (ec[1]),
		.capture_input_pin   (cap),
		.timer_out           (timer_out),
		.timer_out_en        (timer_out_en),
		.match_a_pulse       (match_a_pulse),
		.match_p_pulse       (match_p_pulse),
		.capture_pulse       (capture_pulse)
	);

	always #4 clk_sys = ~clk_sys;
	// Pin rises once every four clocks, so pin-clocked periods are four times longer
	always @(posedge clk_sys) ec <= ec + 2'h1;

	task chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
			err_total++;
		end
	endtask

	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		n = 0;
		// Ack and data are read as sampled at the rising edge, then released there
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
			err_total++;
	endtask

	function automatic logic pl(input bit a);
		return a ? match_a_pulse : match_p_pulse;
	endfunction

	task waitp(input bit a);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while (pl(a) !== 1'b1 && n < 20000);
	endtask

	task end_sim;
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		// Tests need about 50000 cycles
		repeat (90000) @(posedge clk_sys);
		err_total++;
		end_sim();
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			wb(1'b1, ra[i], rw[i]);
			wb(1'b0, ra[i], 8'h00);
			chk(q, re[i]);
		end
		// Second reset after the registers were dirtied
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			wb(1'b0, ra[i], 8'h00);
			chk(q, 8'h00);
		end
		// Clock sources, period byte 1 in plain timer mode
		wb(1'b1, stmc_pkg::ADR_CTRL_B, 8'hc0);
		@(negedge clk_sys);
		chk(timer_out_en, 1'b0);
		wb(1'b1, stmc_pkg::ADR_PERIOD, 8'h01);
		for (int i = 0; i < 7; i++)
		begin
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
			wb(1'b1, stmc_pkg::ADR_CTRL_A, {1'b0, cs[i], 4'h8});
			waitp(1'b0);
			waitp(1'b0);
			chk(n, cg[i]);
		end
		// Clear on switch-on, pause, hold when off
		wb(1'b1, stmc_pkg::ADR_PERIOD, 8'h00);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		chk(q < 8'h08, 1'b1);
		repeat (100) @(posedge clk_sys);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h98);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		qa = q;
		repeat (20) @(posedge clk_sys);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		chk(q, qa);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		chk(q > qa && q - qa < 8'h08, 1'b1);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h10);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		qa = q;
		repeat (20) @(posedge clk_sys);
		wb(1'b1, stmc_pkg::ADR_CNT_LO, 8'h00);
		wb(1'b0, stmc_pkg::ADR_CNT_LO, 8'h00);
		chk(q, qa);
		// Compare-match output, match on 16-bit value 0x20
		wb(1'b1, stmc_pkg::ADR_CMP_LO, 8'h20);
		wb(1'b1, stmc_pkg::ADR_CMP_HI, 8'h00);
		for (int f = 0; f < 4; f++)
		begin
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
			wb(1'b1, stmc_pkg::ADR_CTRL_B, {2'b00, f[1:0], 4'h1});
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
			@(negedge clk_sys);
			chk({timer_out_en, timer_out}, 2'b10);
			waitp(1'b1);
			repeat (2) @(negedge clk_sys);
			chk(timer_out, f > 1);
		end
		waitp(1'b1);
		waitp(1'b1);
		chk(n, 33);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
		wb(1'b1, stmc_pkg::ADR_CTRL_B, 8'h25);
		wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
		@(negedge clk_sys);
		chk(timer_out, 1'b1);
		// PWM, period 256 clocks, duty 0x40, active high
		wb(1'b1, stmc_pkg::ADR_CMP_LO, 8'h40);
		wb(1'b1, stmc_pkg::ADR_PERIOD, 8'h01);
		for (int f = 0; f < 3; f++)
		begin
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
			wb(1'b1, stmc_pkg::ADR_CTRL_B, {2'b10, f[1:0], 4'h8});
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
			h = 0;
			repeat (256)
			begin
				@(negedge clk_sys);
				h += int'(timer_out === 1'b1);
			end
			chk(h, (f == 0) ? 0 : (f == 1) ? 256 : 64);
		end
		// Capture edges for every edge code
		for (int f = 0; f < 4; f++)
		begin
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h00);
			wb(1'b1, stmc_pkg::ADR_CTRL_B, {2'b01, f[1:0], 4'h0});
			wb(1'b1, stmc_pkg::ADR_CTRL_A, 8'h18);
			for (int e = 0; e < 2; e++)
			begin
				@(posedge clk_sys);
				cap <= (e == 0);
				h = 0;
				repeat (6)
				begin
					@(negedge clk_sys);
					h += int'(capture_pulse === 1'b1);
				end
				chk(h, (e == 0) ? (f == 0 || f == 2) : (f == 1 || f == 2));
			end
		end
		end_sim();
	end
endmodule // testbench
